// ### shared/ecx_cfg.svh
`ifndef ECX_CFG_SVH
`define ECX_CFG_SVH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define ECX_ADDR_W 13
`define ECX_IDX_W 11

// ----------------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------------
`define ECX_IDX_CONFIG_A 11'h400
`define ECX_IDX_CONFIG_B 11'h401
`define ECX_IDX_EXT_CTRL 11'h402
`define ECX_IDX_IRQ_LEVEL 11'h403
`define ECX_IDX_IRQ_STATUS 11'h404
`define ECX_IDX_IRQ_MASK 11'h405

// ----------------------------------------------------------------------
// extended_control fields
// ----------------------------------------------------------------------
`define ECX_EC_MODE_HI 7
`define ECX_EC_MODE_LO 5
`define ECX_EC_FAULT_EN_LOW 4
`define ECX_EC_DMA_EN 3
`define ECX_EC_SVC 2
`define ECX_EC_FULL 1
`define ECX_EC_EMPTY 0

// ----------------------------------------------------------------------
// irq_level fields: write level in [4:0], read level in [12:8]
// ----------------------------------------------------------------------
`define ECX_LVL_WR_LO 0
`define ECX_LVL_RD_LO 8

// ----------------------------------------------------------------------
// irq status / mask bit positions
// ----------------------------------------------------------------------
`define ECX_IRQ_SVC 0
`define ECX_IRQ_FAULT 1

// ----------------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------------
`define ECX_RST_MODE 3'h0
`define ECX_RST_CONFIG_A 8'h00
`define ECX_RST_CONFIG_B 8'h00
`define ECX_RST_LEVEL 5'h08
`define ECX_RST_MASK 2'h0
`define ECX_FIFO_DEPTH 5'h10

// ----------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------
`define ECX_RESP_OKAY 2'h0
`define ECX_RESP_SLVERR 2'h2

`endif

// ### shared/ecx_pkg.sv
package ecx_pkg;

    // ------------------------------------------------------------------
    // port modes held in the mode field
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ECX_MODE_SPP = 3'h0,
        ECX_MODE_PS2 = 3'h1,
        ECX_MODE_PPFIFO = 3'h2,
        ECX_MODE_ECP = 3'h3,
        ECX_MODE_EPP = 3'h4,
        ECX_MODE_RSVD = 3'h5,
        ECX_MODE_TEST = 3'h6,
        ECX_MODE_CONFIG = 3'h7
    } ecx_mode_t;

    // ------------------------------------------------------------------
    // register selection from address decode
    // ------------------------------------------------------------------
    typedef enum {
        ECX_SEL_NONE,
        ECX_SEL_CFGA,
        ECX_SEL_CFGB,
        ECX_SEL_EXT,
        ECX_SEL_LVL,
        ECX_SEL_STAT,
        ECX_SEL_MASK
    } ecx_sel_t;

    // ------------------------------------------------------------------
    // axi4-lite carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [12:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [12:0] araddr;
        logic rready;
    } ecx_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ecx_axi_rsp_t;

    // ------------------------------------------------------------------
    // fifo and dma status from the port datapath
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [4:0] count;
        logic direction;
        logic dma_tc;
        logic dma_need;
    } ecx_fifo_stat_t;

endpackage

// ### verilog/ecx_ext_ctrl.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "ecx_cfg.svh"
module ecx_ext_ctrl (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire ecx_pkg::ecx_axi_req_t i_axi_req,
    output ecx_pkg::ecx_axi_rsp_t o_axi_rsp,
    input wire ecx_pkg::ecx_fifo_stat_t i_fifo_stat,
    input wire logic i_peripheral_fault_input_n,
    output logic [2:0] o_mode,
    output logic o_config_mode,
    output logic [7:0] o_config_a,
    output logic [7:0] o_config_b,
    output logic o_dma_req,
    output logic o_irq
);
    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic ecx_pkg::ecx_sel_t ecx_decode(
        input logic [`ECX_ADDR_W-1:0] addr,
        input logic cfg_mode
    );
        logic [`ECX_IDX_W-1:0] idx;
        idx = addr[`ECX_ADDR_W-1:2];
        case (idx)
            `ECX_IDX_CONFIG_A: ecx_decode = cfg_mode ? ecx_pkg::ECX_SEL_CFGA : ecx_pkg::ECX_SEL_NONE;
            `ECX_IDX_CONFIG_B: ecx_decode = cfg_mode ? ecx_pkg::ECX_SEL_CFGB : ecx_pkg::ECX_SEL_NONE;
            `ECX_IDX_EXT_CTRL: ecx_decode = ecx_pkg::ECX_SEL_EXT;
            `ECX_IDX_IRQ_LEVEL: ecx_decode = ecx_pkg::ECX_SEL_LVL;
            `ECX_IDX_IRQ_STATUS: ecx_decode = ecx_pkg::ECX_SEL_STAT;
            `ECX_IDX_IRQ_MASK: ecx_decode = ecx_pkg::ECX_SEL_MASK;
            default: ecx_decode = ecx_pkg::ECX_SEL_NONE;
        endcase
    endfunction
    logic [2:0] mode_reg;
    logic fault_en_low_reg;
    logic dma_en_reg;
    logic svc_reg;
    logic [7:0] cfga_reg;
    logic [7:0] cfgb_reg;
    logic [4:0] wr_level_reg;
    logic [4:0] rd_level_reg;
    logic [1:0] stat_reg;
    logic [1:0] stat_next;
    logic [1:0] mask_reg;
    logic fault_prev_reg;
    logic aw_have_reg;
    logic w_have_reg;
    logic [`ECX_ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic cfg_mode;
    logic ecp_mode;
    logic full;
    logic empty;
    logic [4:0] free_cnt;
    logic svc_set;
    logic fault_evt;
    logic wr_fire;
    logic rd_fire;
    logic wr_ext;
    ecx_pkg::ecx_sel_t wr_sel;
    ecx_pkg::ecx_sel_t rd_sel;
    logic [31:0] rd_mux;
    logic [7:0] ext_view;
    assign cfg_mode = (mode_reg == ecx_pkg::ECX_MODE_CONFIG);
    assign ecp_mode = (mode_reg == ecx_pkg::ECX_MODE_ECP);
    assign full = (i_fifo_stat.count == `ECX_FIFO_DEPTH);
    assign empty = (i_fifo_stat.count == 5'h00);
    assign free_cnt = 5'(`ECX_FIFO_DEPTH - i_fifo_stat.count);
    assign ext_view = {mode_reg, fault_en_low_reg, dma_en_reg, svc_reg, full, empty};
    // ------------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------------
    assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
    assign wr_sel = ecx_decode(awaddr_reg, cfg_mode);
    assign wr_ext = wr_fire & (wr_sel == ecx_pkg::ECX_SEL_EXT) & wstrb_reg[0];

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            aw_have_reg <= 1'b0;
            awaddr_reg <= '0;
        end else if (i_axi_req.awvalid && !aw_have_reg && !bvalid_reg) begin
            aw_have_reg <= 1'b1;
            awaddr_reg <= i_axi_req.awaddr;
        end else if (wr_fire) begin
            aw_have_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            w_have_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else if (i_axi_req.wvalid && !w_have_reg && !bvalid_reg) begin
            w_have_reg <= 1'b1;
            wdata_reg <= i_axi_req.wdata;
            wstrb_reg <= i_axi_req.wstrb;
        end else if (wr_fire) begin
            w_have_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `ECX_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_sel == ecx_pkg::ECX_SEL_NONE) ? `ECX_RESP_SLVERR : `ECX_RESP_OKAY;
        end else if (i_axi_req.bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // extended_control
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_reg <= `ECX_RST_MODE;
            fault_en_low_reg <= 1'b0;
            dma_en_reg <= 1'b0;
        end else if (wr_ext) begin
            mode_reg <= wdata_reg[`ECX_EC_MODE_HI:`ECX_EC_MODE_LO];
            fault_en_low_reg <= wdata_reg[`ECX_EC_FAULT_EN_LOW];
            dma_en_reg <= wdata_reg[`ECX_EC_DMA_EN];
        end
    end

    // service bit: hardware set wins over a software write
    assign svc_set = ~svc_reg & (
        (dma_en_reg & i_fifo_stat.dma_tc) |
        (~dma_en_reg & ~i_fifo_stat.direction & (free_cnt >= wr_level_reg)) |
        (~dma_en_reg & i_fifo_stat.direction & (i_fifo_stat.count >= rd_level_reg)));
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            svc_reg <= 1'b0;
        end else if (svc_set) begin
            svc_reg <= 1'b1;
        end else if (wr_ext) begin
            svc_reg <= wdata_reg[`ECX_EC_SVC];
        end
    end
    assign o_dma_req = dma_en_reg & ~svc_reg & i_fifo_stat.dma_need;
    // ------------------------------------------------------------------
    // configuration and level registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfga_reg <= `ECX_RST_CONFIG_A;
            cfgb_reg <= `ECX_RST_CONFIG_B;
        end else if (wr_fire && wstrb_reg[0]) begin
            if (wr_sel == ecx_pkg::ECX_SEL_CFGA) begin
                cfga_reg <= wdata_reg[7:0];
            end
            if (wr_sel == ecx_pkg::ECX_SEL_CFGB) begin
                cfgb_reg <= wdata_reg[7:0];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_level_reg <= `ECX_RST_LEVEL;
            rd_level_reg <= `ECX_RST_LEVEL;
        end else if (wr_fire && wr_sel == ecx_pkg::ECX_SEL_LVL) begin
            if (wstrb_reg[0]) begin
                wr_level_reg <= wdata_reg[`ECX_LVL_WR_LO +: 5];
            end
            if (wstrb_reg[1]) begin
                rd_level_reg <= wdata_reg[`ECX_LVL_RD_LO +: 5];
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mask_reg <= `ECX_RST_MASK;
        end else if (wr_fire && wr_sel == ecx_pkg::ECX_SEL_MASK && wstrb_reg[0]) begin
            mask_reg <= wdata_reg[1:0];
        end
    end

    // ------------------------------------------------------------------
    // interrupt status, read clears, set wins
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fault_prev_reg <= 1'b1;
        end else begin
            fault_prev_reg <= i_peripheral_fault_input_n;
        end
    end
    assign fault_evt = ecp_mode & ~fault_en_low_reg &
        fault_prev_reg & ~i_peripheral_fault_input_n;
    always_comb begin
        stat_next = stat_reg;
        if (rd_fire && rd_sel == ecx_pkg::ECX_SEL_STAT) begin
            stat_next = 2'h0;
        end
        if (svc_set) begin
            stat_next[`ECX_IRQ_SVC] = 1'b1;
        end
        if (fault_evt) begin
            stat_next[`ECX_IRQ_FAULT] = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stat_reg <= 2'h0;
        end else begin
            stat_reg <= stat_next;
        end
    end
    assign o_irq = |(stat_reg & mask_reg);
    // ------------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------------
    assign rd_fire = i_axi_req.arvalid & ~rvalid_reg;
    assign rd_sel = ecx_decode(i_axi_req.araddr, cfg_mode);
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (rd_sel)
            ecx_pkg::ECX_SEL_CFGA: rd_mux[7:0] = cfga_reg;
            ecx_pkg::ECX_SEL_CFGB: rd_mux[7:0] = cfgb_reg;
            ecx_pkg::ECX_SEL_EXT: rd_mux[7:0] = ext_view;
            ecx_pkg::ECX_SEL_LVL: begin
                rd_mux[`ECX_LVL_WR_LO +: 5] = wr_level_reg;
                rd_mux[`ECX_LVL_RD_LO +: 5] = rd_level_reg;
            end
            ecx_pkg::ECX_SEL_STAT: rd_mux[1:0] = stat_reg;
            ecx_pkg::ECX_SEL_MASK: rd_mux[1:0] = mask_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= `ECX_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= (rd_sel == ecx_pkg::ECX_SEL_NONE) ? `ECX_RESP_SLVERR : `ECX_RESP_OKAY;
        end else if (i_axi_req.rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    always_comb begin
        o_axi_rsp.awready = ~aw_have_reg & ~bvalid_reg;
        o_axi_rsp.wready = ~w_have_reg & ~bvalid_reg;
        o_axi_rsp.bvalid = bvalid_reg;
        o_axi_rsp.bresp = bresp_reg;
        o_axi_rsp.arready = ~rvalid_reg;
        o_axi_rsp.rvalid = rvalid_reg;
        o_axi_rsp.rdata = rdata_reg;
        o_axi_rsp.rresp = rresp_reg;
    end
    assign o_mode = mode_reg;
    assign o_config_mode = cfg_mode;
    assign o_config_a = cfga_reg;
    assign o_config_b = cfgb_reg;
    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    sequence s_ext_write;
        wr_ext;
    endsequence
    sequence s_fault_fall;
        ecp_mode && !fault_en_low_reg && fault_prev_reg && !i_peripheral_fault_input_n;
    endsequence
    chk_mode_write_lands: assert property (
        s_ext_write |=> mode_reg == $past(wdata_reg[7:5]))
        else $error("mode field did not take written value");
    chk_cfg_write_gate: assert property (
        wr_fire && !cfg_mode |=> $stable(cfga_reg) && $stable(cfgb_reg))
        else $error("config register changed outside configuration mode");
    chk_fault_edge_irq: assert property (
        s_fault_fall |=> stat_reg[`ECX_IRQ_FAULT])
        else $error("fault falling edge not latched");
    chk_fault_en_block: assert property (
        $rose(stat_reg[`ECX_IRQ_FAULT]) |-> !$past(fault_en_low_reg) && $past(ecp_mode))
        else $error("fault status set while fault interrupt disabled");
    chk_dma_off_req: assert property (
        !dma_en_reg |-> !o_dma_req)
        else $error("dma request while dma disabled");
    chk_svc_sticky: assert property (
        svc_reg && !wr_ext |=> svc_reg)
        else $error("service bit cleared without a software write");
    chk_svc_tc_set: assert property (
        dma_en_reg && !svc_reg && i_fifo_stat.dma_tc |=> svc_reg && stat_reg[`ECX_IRQ_SVC])
        else $error("terminal count did not set service bit");
    chk_svc_wr_level: assert property (
        !dma_en_reg && !svc_reg && !i_fifo_stat.direction && free_cnt >= wr_level_reg
        |=> svc_reg)
        else $error("write level did not set service bit");
    chk_svc_rd_level: assert property (
        !dma_en_reg && !svc_reg && i_fifo_stat.direction &&
        i_fifo_stat.count >= rd_level_reg |=> svc_reg)
        else $error("read level did not set service bit");
    chk_svc_suppress: assert property (
        svc_reg |-> !o_dma_req ##1 !$rose(stat_reg[`ECX_IRQ_SVC]))
        else $error("dma or service event while service bit set");
    chk_full_flag_read: assert property (
        rd_fire && rd_sel == ecx_pkg::ECX_SEL_EXT
        |=> rdata_reg[`ECX_EC_FULL] == ($past(i_fifo_stat.count) == `ECX_FIFO_DEPTH))
        else $error("full flag wrong");
    chk_empty_flag_read: assert property (
        rd_fire && rd_sel == ecx_pkg::ECX_SEL_EXT
        |=> rdata_reg[`ECX_EC_EMPTY] == ($past(i_fifo_stat.count) == 5'h00))
        else $error("empty flag wrong");
endmodule // ecx_ext_ctrl

// ### sim/ecx_dma_model.sv
`timescale 1ns/10ps
module ecx_dma_model #(
    parameter int BURST = 3
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_dma_req,
    input wire logic i_load,
    input wire logic [4:0] i_count,
    input wire logic i_direction,
    input wire logic i_need,
    output ecx_pkg::ecx_fifo_stat_t o_fifo_stat
);
    // ------------------------------------------------------------------
    // dma controller: one byte per granted cycle, tc registered one cycle after the last
    // ------------------------------------------------------------------
    logic [3:0] left_reg;
    logic tc_reg;
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            left_reg <= 4'h0;
        end else if (i_load) begin
            left_reg <= 4'(BURST);
        end else if (i_dma_req && left_reg != 4'h0) begin
            left_reg <= left_reg - 4'h1;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tc_reg <= 1'h0;
        end else begin
            tc_reg <= i_dma_req && !i_load && left_reg == 4'h1;
        end
    end
    assign o_fifo_stat = {i_count, i_direction, tc_reg, i_need};
endmodule // ecx_dma_model

// ### sim/tb_top.sv
`timescale 1ns/10ps
`include "ecx_cfg.svh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin err_total++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic i_clk_sys = 1'h0;
    logic i_arst_n = 1'h0;
    ecx_pkg::ecx_axi_req_t req = '0;
    ecx_pkg::ecx_axi_rsp_t rsp;
    ecx_pkg::ecx_fifo_stat_t fstat;
    logic fault_n = 1'h1;
    logic [4:0] cnt = 5'h10;
    logic dir = 1'h0;
    logic need = 1'h0;
    logic load = 1'h0;
    logic [2:0] mode;
    logic cfg_mode;
    logic dma_req;
    logic irq;
    logic [7:0] cfga;
    logic [7:0] cfgb;
    int err_total = 0;
    int compares = 0;
    initial begin
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    ecx_ext_ctrl u_dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_axi_req(req),
        .o_axi_rsp(rsp), .i_fifo_stat(fstat), .i_peripheral_fault_input_n(fault_n),
        .o_mode(mode), .o_config_mode(cfg_mode), .o_config_a(cfga), .o_config_b(cfgb),
        .o_dma_req(dma_req), .o_irq(irq));
    ecx_dma_model u_dma (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_dma_req(dma_req),
        .i_load(load), .i_count(cnt), .i_direction(dir), .i_need(need), .o_fifo_stat(fstat));
    // ------------------------------------------------------------------
    // bus, fault pulse and result tasks
    // ------------------------------------------------------------------
    task automatic results();
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    task automatic wr(input logic [10:0] idx, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        int n;
        @(posedge i_clk_sys);
        req.awaddr <= {idx, 2'h0};
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'h1;
        req.wvalid <= 1'h1;
        req.bready <= 1'h1;
        b = 1'h0;
        n = 0;
        while (!b && n < 50) begin
            @(negedge i_clk_sys);
            aw = req.awvalid && rsp.awready;
            w = req.wvalid && rsp.wready;
            b = req.bready && rsp.bvalid;
            if (b) `CHK("bresp", er, rsp.bresp)
            @(posedge i_clk_sys);
            if (aw) req.awvalid <= 1'h0;
            if (w) req.wvalid <= 1'h0;
            if (b) req.bready <= 1'h0;
            n++;
        end
        if (!b) `CHK("bvalid", 1'h1, b)
    endtask
    task automatic rd(input logic [10:0] idx, input logic [31:0] ex, input logic [1:0] er);
        logic a, r;
        int n;
        @(posedge i_clk_sys);
        req.araddr <= {idx, 2'h0};
        req.arvalid <= 1'h1;
        req.rready <= 1'h1;
        r = 1'h0;
        n = 0;
        while (!r && n < 50) begin
            @(negedge i_clk_sys);
            a = req.arvalid && rsp.arready;
            r = req.rready && rsp.rvalid;
            if (r) `CHK("rdata", ex, rsp.rdata)
            if (r) `CHK("rresp", er, rsp.rresp)
            @(posedge i_clk_sys);
            if (a) req.arvalid <= 1'h0;
            if (r) req.rready <= 1'h0;
            n++;
        end
        if (!r) `CHK("rvalid", 1'h1, r)
    endtask
    task automatic pulse_fault();
        @(posedge i_clk_sys);
        fault_n <= 1'h0;
        tick(3);
        fault_n <= 1'h1;
        tick(3);
    endtask
    initial begin
        #200000;
        `CHK("watchdog", 1'h0, 1'h1)
        results();
    end
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        tick(4);
        i_arst_n <= 1'h1;
        rd(`ECX_IDX_EXT_CTRL, 32'h02, `ECX_RESP_OKAY);
        rd(`ECX_IDX_IRQ_LEVEL, 32'h0808, `ECX_RESP_OKAY);
        rd(`ECX_IDX_IRQ_MASK, 32'h0, `ECX_RESP_OKAY);
        wr(`ECX_IDX_EXT_CTRL, 32'h03, `ECX_RESP_OKAY);
        rd(`ECX_IDX_EXT_CTRL, 32'h02, `ECX_RESP_OKAY);
        rd(11'h3FF, 32'h0, `ECX_RESP_SLVERR);
        wr(11'h3FF, 32'hFF, `ECX_RESP_SLVERR);
        rd(`ECX_IDX_CONFIG_A, 32'h0, `ECX_RESP_SLVERR);
        for (int m = 0; m < 8; m++) begin
            wr(`ECX_IDX_EXT_CTRL, {24'h0, m[2:0], 5'h00}, `ECX_RESP_OKAY);
            rd(`ECX_IDX_EXT_CTRL, {24'h0, m[2:0], 5'h02}, `ECX_RESP_OKAY);
            `CHK("mode", m[2:0], mode)
            `CHK("cfg_mode", (m == 7), cfg_mode)
            if (m == 7) begin
                wr(`ECX_IDX_CONFIG_A, 32'h5A, `ECX_RESP_OKAY);
                wr(`ECX_IDX_CONFIG_B, 32'hA5, `ECX_RESP_OKAY);
                rd(`ECX_IDX_CONFIG_A, 32'h5A, `ECX_RESP_OKAY);
                rd(`ECX_IDX_CONFIG_B, 32'hA5, `ECX_RESP_OKAY);
                `CHK("cfga", 8'h5A, cfga)
                `CHK("cfgb", 8'hA5, cfgb)
            end
            wr(`ECX_IDX_EXT_CTRL, 32'h0, `ECX_RESP_OKAY);
        end
        cnt <= 5'h09;
        tick(2);
        rd(`ECX_IDX_EXT_CTRL, 32'h00, `ECX_RESP_OKAY);
        cnt <= 5'h08;
        tick(2);
        rd(`ECX_IDX_EXT_CTRL, 32'h04, `ECX_RESP_OKAY);
        rd(`ECX_IDX_IRQ_STATUS, 32'h1, `ECX_RESP_OKAY);
        `CHK("irq", 1'h0, irq)
        wr(`ECX_IDX_IRQ_MASK, 32'h1, `ECX_RESP_OKAY);
        rd(`ECX_IDX_IRQ_STATUS, 32'h0, `ECX_RESP_OKAY);
        wr(`ECX_IDX_EXT_CTRL, 32'h0, `ECX_RESP_OKAY);
        tick(2);
        `CHK("irq", 1'h1, irq)
        rd(`ECX_IDX_IRQ_STATUS, 32'h1, `ECX_RESP_OKAY);
        tick(1);
        `CHK("irq", 1'h0, irq)
        cnt <= 5'h00;
        tick(2);
        rd(`ECX_IDX_EXT_CTRL, 32'h05, `ECX_RESP_OKAY);
        dir <= 1'h1;
        cnt <= 5'h07;
        tick(2);
        wr(`ECX_IDX_EXT_CTRL, 32'h0, `ECX_RESP_OKAY);
        rd(`ECX_IDX_EXT_CTRL, 32'h00, `ECX_RESP_OKAY);
        cnt <= 5'h08;
        tick(2);
        rd(`ECX_IDX_EXT_CTRL, 32'h04, `ECX_RESP_OKAY);
        rd(`ECX_IDX_IRQ_STATUS, 32'h1, `ECX_RESP_OKAY);
        dir <= 1'h0;
        cnt <= 5'h04;
        need <= 1'h1;
        tick(2);
        wr(`ECX_IDX_EXT_CTRL, 32'h08, `ECX_RESP_OKAY);
        rd(`ECX_IDX_EXT_CTRL, 32'h08, `ECX_RESP_OKAY);
        `CHK("dma_req", 1'h1, dma_req)
        load <= 1'h1;
        tick(1);
        load <= 1'h0;
        tick(8);
        `CHK("dma_req", 1'h0, dma_req)
        rd(`ECX_IDX_EXT_CTRL, 32'h0C, `ECX_RESP_OKAY);
        rd(`ECX_IDX_IRQ_STATUS, 32'h1, `ECX_RESP_OKAY);
        cnt <= 5'h10;
        tick(2);
        wr(`ECX_IDX_EXT_CTRL, 32'h0, `ECX_RESP_OKAY);
        tick(2);
        `CHK("dma_req", 1'h0, dma_req)
        need <= 1'h0;
        wr(`ECX_IDX_IRQ_MASK, 32'h3, `ECX_RESP_OKAY);
        rd(`ECX_IDX_IRQ_STATUS, 32'h0, `ECX_RESP_OKAY);
        wr(`ECX_IDX_EXT_CTRL, 32'h60, `ECX_RESP_OKAY);
        pulse_fault();
        `CHK("irq", 1'h1, irq)
        rd(`ECX_IDX_IRQ_STATUS, 32'h2, `ECX_RESP_OKAY);
        wr(`ECX_IDX_EXT_CTRL, 32'h70, `ECX_RESP_OKAY);
        rd(`ECX_IDX_EXT_CTRL, 32'h72, `ECX_RESP_OKAY);
        pulse_fault();
        rd(`ECX_IDX_IRQ_STATUS, 32'h0, `ECX_RESP_OKAY);
        wr(`ECX_IDX_EXT_CTRL, 32'h0, `ECX_RESP_OKAY);
        pulse_fault();
        rd(`ECX_IDX_IRQ_STATUS, 32'h0, `ECX_RESP_OKAY);
        wr(`ECX_IDX_IRQ_LEVEL, 32'h0C04, `ECX_RESP_OKAY);
        rd(`ECX_IDX_IRQ_LEVEL, 32'h0C04, `ECX_RESP_OKAY);
        cnt <= 5'h0D;
        tick(2);
        rd(`ECX_IDX_EXT_CTRL, 32'h00, `ECX_RESP_OKAY);
        cnt <= 5'h0C;
        tick(2);
        rd(`ECX_IDX_EXT_CTRL, 32'h04, `ECX_RESP_OKAY);
        results();
    end
endmodule // tb_top
